// [bench/ssdpc_ctrl_bench.sv]
// Self-checking bench for the SRAM data port control
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end

// ==========================================================
// Bench top
module ssdpc_ctrl_bench
	import ssdpc_pkg::*;
;
	logic        clock;
	logic        sys_rst;
	logic        mode_v;
	logic        oe_n_v;
	logic        data_lane_oe;
	logic        parity_lane_oe;
	int          fail_count;
	int          num_checks;
	int          cycles;
	ssdpc_pin_s  pins;
	ssdpc_word_t wire_word;
	wire ssdpc_word_t dev_word;
	ssdpc_word_t exp_mem [int];
	ssdpc_word_t q [$];

	initial begin
		clock = 1'h0;
		forever #12.5 clock = ~clock;
	end

	ssdpc_ctrl_model ssdpc_ctrl_model_i (.clock(clock), .dev_word(dev_word),
		.dev_oe(data_lane_oe), .pins(pins), .wire_word(wire_word));

	ssdpc_ctrl ssdpc_ctrl_i (.clock(clock), .sys_rst(sys_rst),
		.clock_qualify_n(pins.cq_n), .chip_select_1_n(pins.ce1_n),
		.chip_select_2(pins.ce2), .chip_select_3_n(pins.ce3_n),
		.write_request_n(pins.we_n), .lane_write_select_0_n(pins.bws_n[0]),
		.lane_write_select_1_n(pins.bws_n[1]),
		.lane_write_select_2_n(pins.bws_n[2]),
		.lane_write_select_3_n(pins.bws_n[3]),
		.advance_or_load(pins.adv), .address(pins.addr),
		.output_enable_n(pins.oe_n), .burst_order(pins.mode),
		.data_lane_0_in(wire_word[0][7:0]), .data_lane_1_in(wire_word[1][7:0]),
		.data_lane_2_in(wire_word[2][7:0]), .data_lane_3_in(wire_word[3][7:0]),
		.data_lane_0_out(dev_word[0][7:0]), .data_lane_1_out(dev_word[1][7:0]),
		.data_lane_2_out(dev_word[2][7:0]), .data_lane_3_out(dev_word[3][7:0]),
		.data_lane_oe(data_lane_oe),
		.parity_lane_0_in(wire_word[0][8]), .parity_lane_1_in(wire_word[1][8]),
		.parity_lane_2_in(wire_word[2][8]), .parity_lane_3_in(wire_word[3][8]),
		.parity_lane_0_out(dev_word[0][8]), .parity_lane_1_out(dev_word[1][8]),
		.parity_lane_2_out(dev_word[2][8]), .parity_lane_3_out(dev_word[3][8]),
		.parity_lane_oe(parity_lane_oe));

	// ==========================================================
	// Helpers
	function automatic ssdpc_word_t w(input int i);
		for (int k = 0; k < 4; k++) w[k] = 9'(i * 67 + k * 131 + 5);
	endfunction : w

	function automatic int ba(input int b, input int i);
		return mode_v ? (b ^ i) : ((b & ~3) | ((b + i) & 3));
	endfunction : ba

	// Kinds: 0 deselect, 1 read load, 2 write load, 3 advance, 4 suspend
	task automatic cyc(input int k, input int a, input logic [3:0] bw,
		input logic drv, input ssdpc_word_t d);
		ssdpc_pin_s p;
		p       = '0;
		p.cq_n  = (k == 4);
		p.ce1_n = (k == 0 || k == 4);
		p.ce2   = 1'h1;
		p.we_n  = (k != 2);
		p.bws_n = bw;
		p.adv   = (k >= 3);
		p.addr  = 18'(a);
		p.oe_n  = oe_n_v;
		p.mode  = mode_v;
		ssdpc_ctrl_model_i.step(p, drv, d);
	endtask : cyc

	// Keeps each driven word that differs from the last one kept; held outputs are not repeated
	task automatic collect(input int n);
		q.delete();
		repeat (n) begin
			@(posedge clock);
			#1;
			`CHK(parity_lane_oe, data_lane_oe)
			if (data_lane_oe === 1'h1 && (q.size() == 0 || q[$] !== dev_word))
				q.push_back(dev_word);
		end
	endtask : collect

	task automatic do_reset(input logic m);
		mode_v = m;
		@(posedge clock);
		sys_rst <= 1'h1;
		repeat (5) cyc(0, 0, 4'hf, 1'h0, '0);
		sys_rst <= 1'h0;
	endtask : do_reset

	// ==========================================================
	// Scenarios
	task automatic wr_burst(input int b, input int n);
		oe_n_v = 1'h0;
		fork
			begin
				cyc(2, b, 4'h0, 1'h0, '0);
				for (int i = 0; i < 4; i++) begin
					cyc(i < 3 ? 3 : 0, 0, 4'h0, 1'h1, w(n + i));
					exp_mem[ba(b, i)] = w(n + i);
				end
				cyc(0, 0, 4'hf, 1'h0, '0);
			end
			collect(10);
		join
		`CHK(q.size(), 0)
	endtask : wr_burst

	task automatic rd_burst(input int b, input logic susp);
		oe_n_v = 1'h0;
		fork
			begin
				cyc(1, b, 4'hf, 1'h0, '0);
				cyc(3, 0, 4'hf, 1'h0, '0);
				if (susp) repeat (3) cyc(4, 0, 4'hf, 1'h0, '0);
				repeat (2) cyc(3, 0, 4'hf, 1'h0, '0);
				cyc(0, 0, 4'hf, 1'h0, '0);
			end
			collect(14);
		join
		`CHK(q.size(), 3)
		for (int i = 0; i < 3 && i < q.size(); i++)
			`CHK(q[i], exp_mem[ba(b, i + 1)])
		`CHK(data_lane_oe, 1'h0)
	endtask : rd_burst

	task automatic rd_pair(input int a, input int b, input logic hi);
		oe_n_v = hi;
		fork
			begin
				cyc(1, a, 4'hf, 1'h0, '0);
				cyc(1, b, 4'hf, 1'h0, '0);
				cyc(0, 0, 4'hf, 1'h0, '0);
			end
			collect(10);
		join
		`CHK(q.size(), hi ? 0 : 1)
		if (!hi && q.size() == 1)
			`CHK(q[0], exp_mem[b])
	endtask : rd_pair

	task automatic lane_wr(input int a, input int n, input logic [3:0] bw);
		ssdpc_word_t t;
		t      = w(n);
		oe_n_v = 1'h1;
		cyc(2, a, bw, 1'h0, '0);
		cyc(0, 0, 4'hf, 1'h1, t);
		for (int k = 0; k < 4; k++)
			if (!bw[k]) exp_mem[a][k] = t[k];
		repeat (5) cyc(0, 0, 4'hf, 1'h0, '0);
	endtask : lane_wr

	task automatic report_and_stop();
		if (fail_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	// Far above the hundred or so cycles the sequence needs
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			report_and_stop();
		end
	end

	initial begin
		sys_rst    = 1'h1;
		mode_v     = 1'h1;
		oe_n_v     = 1'h1;
		fail_count = 0;
		num_checks = 0;
		cycles     = 0;
		do_reset(1'h1);
		wr_burst(1, 0);
		rd_burst(1, 1'h1);
		rd_pair(1, 2, 1'h1);
		rd_pair(1, 2, 1'h0);
		lane_wr(2, 9, 4'h5);
		rd_pair(1, 2, 1'h0);
		do_reset(1'h0);
		wr_burst(5, 20);
		rd_burst(5, 1'h0);
		report_and_stop();
	end
endmodule : ssdpc_ctrl_bench

// [bench/ssdpc_ctrl_model.sv]
// Memory controller model driving the SRAM data port pins
`timescale 1ns/1ps

// ==========================================================
// Controller model
module ssdpc_ctrl_model
	import ssdpc_pkg::*;
(
	// Clock
	input  wire logic        clock,
	// Device side
	input  wire ssdpc_word_t dev_word,
	input  wire logic        dev_oe,
	// Pins
	output ssdpc_pin_s       pins,
	output ssdpc_word_t      wire_word
);
	logic        drive;
	ssdpc_word_t wdata;
	ssdpc_word_t last;

	initial begin
		pins  = '1;
		drive = 1'h0;
		wdata = '0;
		last  = '0;
	end

	// Released lanes toggle so a stale value never reads as valid
	assign wire_word = (dev_oe === 1'h1) ? dev_word :
		drive ? wdata : ~last;
	always @(posedge clock) last <= ~last;

	task automatic step(input ssdpc_pin_s p, input logic d,
		input ssdpc_word_t v);
		@(posedge clock);
		pins  <= p;
		drive <= d;
		wdata <= v;
	endtask : step
endmodule : ssdpc_ctrl_model

// [src/ssdpc_ctrl.sv]
// Data port control of a synchronous flow-through burst SRAM, with FIFO
`timescale 1ns/1ps

// ==========================================================
// Write buffer
module ssdpc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             sys_rst,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;

	assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) &&
	                     (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
	assign out_valid = (wr_ptr != rd_ptr);
	assign out_data  = store[rd_ptr[AW-1:0]];

	always_ff @(posedge clock) begin
		if (in_valid && in_ready) begin
			store[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wr_ptr <= '0;
		end else if (in_valid && in_ready) begin
			wr_ptr <= wr_ptr + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rd_ptr <= '0;
		end else if (out_valid && out_ready) begin
			rd_ptr <= rd_ptr + 1'b1;
		end
	end

endmodule : ssdpc_fifo

// ==========================================================
// Device side
// Function
// - Qualify low: act on edge, capture inputs (here only while the write buffer has room)
// - Qualify high: ignore edges, hold state
// - Qualify high never deselects; cycle stretches
// - Input data lanes captured on rising edge
// - Read drives word at previously sampled address
// - Drive only with output enable low
// - Float data during every write data phase
// - Float first clock after leaving deselect
// - Deselected device always floats data
// - Parity lanes behave like data lanes
// - Parity lane written only with lane select
// - Strap high interleaved, low linear, float high
// - Lane selects active low, qualified by write
// - Advance steps burst counter, load takes address
module ssdpc_ctrl
	import ssdpc_pkg::*;
(
	// Clock and reset
	input  wire logic                    clock,
	input  wire logic                    sys_rst,
	// Control pins
	input  wire logic                    clock_qualify_n,
	input  wire logic                    chip_select_1_n,
	input  wire logic                    chip_select_2,
	input  wire logic                    chip_select_3_n,
	input  wire logic                    write_request_n,
	input  wire logic                    lane_write_select_0_n,
	input  wire logic                    lane_write_select_1_n,
	input  wire logic                    lane_write_select_2_n,
	input  wire logic                    lane_write_select_3_n,
	input  wire logic                    advance_or_load,
	input  wire logic [SSDPC_ADDR_W-1:0] address,
	input  wire logic                    output_enable_n,
	input  wire logic                    burst_order,
	// Data lanes, pin side
	input  wire logic [SSDPC_BYTE_W-1:0] data_lane_0_in,
	input  wire logic [SSDPC_BYTE_W-1:0] data_lane_1_in,
	input  wire logic [SSDPC_BYTE_W-1:0] data_lane_2_in,
	input  wire logic [SSDPC_BYTE_W-1:0] data_lane_3_in,
	output logic      [SSDPC_BYTE_W-1:0] data_lane_0_out,
	output logic      [SSDPC_BYTE_W-1:0] data_lane_1_out,
	output logic      [SSDPC_BYTE_W-1:0] data_lane_2_out,
	output logic      [SSDPC_BYTE_W-1:0] data_lane_3_out,
	output logic                         data_lane_oe,
	// Parity lanes, pin side
	input  wire logic                    parity_lane_0_in,
	input  wire logic                    parity_lane_1_in,
	input  wire logic                    parity_lane_2_in,
	input  wire logic                    parity_lane_3_in,
	output logic                         parity_lane_0_out,
	output logic                         parity_lane_1_out,
	output logic                         parity_lane_2_out,
	output logic                         parity_lane_3_out,
	output logic                         parity_lane_oe
);

	// ==========================================================
	// Pin synchronisers
	ssdpc_pin_s pin_raw;
	ssdpc_pin_s pin_meta;
	ssdpc_pin_s pin;

	assign pin_raw.cq_n  = clock_qualify_n;
	assign pin_raw.ce1_n = chip_select_1_n;
	assign pin_raw.ce2   = chip_select_2;
	assign pin_raw.ce3_n = chip_select_3_n;
	assign pin_raw.we_n  = write_request_n;
	assign pin_raw.bws_n = {lane_write_select_3_n, lane_write_select_2_n,
	                        lane_write_select_1_n, lane_write_select_0_n};
	assign pin_raw.adv   = advance_or_load;
	assign pin_raw.addr  = address;
	assign pin_raw.oe_n  = output_enable_n;
	assign pin_raw.mode  = burst_order;
	assign pin_raw.lanes = {parity_lane_3_in, data_lane_3_in,
	                        parity_lane_2_in, data_lane_2_in,
	                        parity_lane_1_in, data_lane_1_in,
	                        parity_lane_0_in, data_lane_0_in};

	// All ones parks the port suspended, floating, strap high
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pin_meta <= '1;
			pin      <= '1;
		end else begin
			pin_meta <= pin_raw;
			pin      <= pin_meta;
		end
	end

	// ==========================================================
	// Clock qualification and sequencing
	ssdpc_state_e            state;
	ssdpc_state_e            next_state;
	logic [SSDPC_ADDR_W-1:0] base;
	logic [SSDPC_ADDR_W-1:0] next_base;
	logic [1:0]              burst_cnt;
	logic [1:0]              next_cnt;
	logic [SSDPC_LANES-1:0]  bws_n;
	logic                    first_after_desel;
	logic                    next_first;
	logic                    selected;
	logic                    qual;
	logic                    read_now;
	logic [SSDPC_ADDR_W-1:0] cur_addr;
	logic [SSDPC_ADDR_W-1:0] next_addr;
	logic                    wq_in_ready;
	logic                    wq_out_valid;
	logic                    wq_out_ready;
	ssdpc_wr_s               wq_in;
	ssdpc_wr_s               wq_out;

	function automatic logic [SSDPC_ADDR_W-1:0] burst_addr(
		input logic [SSDPC_ADDR_W-1:0] b,
		input logic [1:0]              c,
		input logic                    interleave
	);
		logic [1:0] low;
		low = interleave ? (b[1:0] ^ c) : 2'(b[1:0] + c);
		return {b[SSDPC_ADDR_W-1:2], low};
	endfunction : burst_addr

	assign selected = !pin.ce1_n && pin.ce2 && !pin.ce3_n;
	// A full write buffer stretches the cycle like a suspended clock
	assign qual     = !pin.cq_n && wq_in_ready;
	assign cur_addr = burst_addr(base, burst_cnt, pin.mode);

	always_comb begin
		next_state = state;
		next_base  = base;
		next_cnt   = burst_cnt;
		next_first = first_after_desel;
		if (qual) begin
			if (!pin.adv) begin
				if (selected) begin
					next_state = pin.we_n ? ST_READ : ST_WRITE;
					next_base  = pin.addr;
					next_cnt   = SSDPC_CNT_RST;
					next_first = (state == ST_DESEL);
				end else begin
					next_state = ST_DESEL;
					next_first = 1'b0;
				end
			end else if (state != ST_DESEL) begin
				next_cnt   = 2'(burst_cnt + 2'h1);
				next_first = 1'b0;
			end
		end
	end

	assign next_addr = burst_addr(next_base, next_cnt, pin.mode);
	assign read_now  = qual && (next_state == ST_READ);

	// Suspended edges leave the state, base, burst count and first-clock flag as they were
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state             <= ST_DESEL;
			base              <= '0;
			burst_cnt         <= SSDPC_CNT_RST;
			first_after_desel <= 1'b0;
		end else if (qual) begin
			state             <= next_state;
			base              <= next_base;
			burst_cnt         <= next_cnt;
			first_after_desel <= next_first;
		end
	end

	// Lane selects travel with each address of a burst
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			bws_n <= '1;
		end else if (qual && (next_state == ST_WRITE)) begin
			bws_n <= pin.bws_n;
		end
	end

	// ==========================================================
	// Write data capture and buffer
	assign wq_in.addr  = cur_addr;
	assign wq_in.bws_n = bws_n;
	assign wq_in.lanes = pin.lanes;

	// A read in the same cycle wins the lane arrays; draining waits
	assign wq_out_ready = !read_now;

	ssdpc_fifo #(
		.WIDTH ($bits(ssdpc_wr_s)),
		.DEPTH (SSDPC_FIFO_D)
	) ssdpc_fifo_i (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.in_valid  (qual && (state == ST_WRITE)),
		.in_ready  (wq_in_ready),
		.in_data   (wq_in),
		.out_valid (wq_out_valid),
		.out_ready (wq_out_ready),
		.out_data  (wq_out)
	);

	// ==========================================================
	// Lane arrays and read data
	logic [SSDPC_LANE_W-1:0] out_lane [SSDPC_LANES];

	for (genvar i = 0; i < SSDPC_LANES; i++) begin : g_lane
		logic [SSDPC_LANE_W-1:0] lane_mem [SSDPC_DEPTH];

		always_ff @(posedge clock) begin
			if (wq_out_valid && wq_out_ready && !wq_out.bws_n[i]) begin
				lane_mem[wq_out.addr] <= wq_out.lanes[i];
			end
		end

		always_ff @(posedge clock) begin
			if (sys_rst) begin
				out_lane[i] <= '0;
			end else if (read_now) begin
				out_lane[i] <= lane_mem[next_addr];
			end
		end
	end

	// ==========================================================
	// Output drive control
	logic drive_en;

	// Output enable acts on every edge; only the sequencing is held
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			drive_en <= 1'b0;
		end else if (qual) begin
			drive_en <= (next_state == ST_READ) && !next_first &&
			            !pin.oe_n;
		end else begin
			drive_en <= (state == ST_READ) && !first_after_desel &&
			            !pin.oe_n;
		end
	end

	assign data_lane_oe      = drive_en;
	assign parity_lane_oe    = drive_en;
	assign data_lane_0_out   = out_lane[0][SSDPC_BYTE_W-1:0];
	assign data_lane_1_out   = out_lane[1][SSDPC_BYTE_W-1:0];
	assign data_lane_2_out   = out_lane[2][SSDPC_BYTE_W-1:0];
	assign data_lane_3_out   = out_lane[3][SSDPC_BYTE_W-1:0];
	assign parity_lane_0_out = out_lane[0][SSDPC_PAR_BIT];
	assign parity_lane_1_out = out_lane[1][SSDPC_PAR_BIT];
	assign parity_lane_2_out = out_lane[2][SSDPC_PAR_BIT];
	assign parity_lane_3_out = out_lane[3][SSDPC_PAR_BIT];

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	a_suspend_holds_state: assert property (
		!qual |=> $stable(state) && $stable(burst_cnt) && $stable(base)
	) else $error("state moved on a suspended edge");

	a_load_takes_address: assert property (
		qual && !pin.adv && selected |=> base == $past(pin.addr)
	) else $error("load did not take the sampled address");

	a_burst_counter_step: assert property (
		qual && pin.adv && (state != ST_DESEL)
		|=> burst_cnt == 2'($past(burst_cnt) + 2'h1)
	) else $error("burst counter did not step");

	a_oe_high_floats: assert property (
		pin.oe_n |=> !drive_en
	) else $error("lanes driven with output enable high");

	a_drive_only_read: assert property (
		drive_en |-> (state == ST_READ) && !first_after_desel
	) else $error("lanes driven outside a read");

	a_first_edge_floats: assert property (
		qual && (state == ST_DESEL) && (next_state == ST_READ)
		|=> !drive_en && first_after_desel
	) else $error("lanes driven on first clock after deselect");

	a_desel_floats: assert property (
		(state == ST_DESEL) |-> !data_lane_oe && !parity_lane_oe
	) else $error("lanes driven while deselected");

	a_write_data_queued: assert property (
		qual && (state == ST_WRITE) |=> wq_out_valid
	) else $error("write data phase left nothing to store");

	a_burst_order: assert property (
		(state != ST_DESEL) && pin.mode
		|-> cur_addr[1:0] == (base[1:0] ^ burst_cnt)
	) else $error("interleaved burst order wrong");

	c_read_driven: cover property (
		read_now ##1 drive_en
	);
	c_write_stored: cover property (
		qual && (state == ST_WRITE) ##[1:9] wq_out_valid && wq_out_ready
	);
	c_burst_four: cover property (
		qual && pin.adv && (burst_cnt == 2'h3)
	);
	c_suspended_read: cover property (
		drive_en && !qual ##1 drive_en
	);

endmodule : ssdpc_ctrl

// [src/ssdpc_pkg.sv]
// Shared constants and carriers for the synchronous SRAM data port
package ssdpc_pkg;

	// ==========================================================
	// Geometry
	localparam int SSDPC_ADDR_W  = 18;
	localparam int SSDPC_LANES   = 4;
	localparam int SSDPC_LANE_W  = 9;
	localparam int SSDPC_BYTE_W  = 8;
	localparam int SSDPC_PAR_BIT = 8;
	localparam int SSDPC_DEPTH   = 262144;
	localparam int SSDPC_FIFO_D  = 8;

	// ==========================================================
	// Reset values
	localparam logic [1:0] SSDPC_CNT_RST  = 2'h0;
	localparam logic       SSDPC_MODE_RST = 1'h1;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		ST_DESEL,
		ST_READ,
		ST_WRITE
	} ssdpc_state_e;

	typedef logic [SSDPC_LANES-1:0][SSDPC_LANE_W-1:0] ssdpc_word_t;

	typedef struct packed {
		logic                    cq_n;
		logic                    ce1_n;
		logic                    ce2;
		logic                    ce3_n;
		logic                    we_n;
		logic [SSDPC_LANES-1:0]  bws_n;
		logic                    adv;
		logic [SSDPC_ADDR_W-1:0] addr;
		logic                    oe_n;
		logic                    mode;
		ssdpc_word_t             lanes;
	} ssdpc_pin_s;

	typedef struct packed {
		logic [SSDPC_ADDR_W-1:0] addr;
		logic [SSDPC_LANES-1:0]  bws_n;
		ssdpc_word_t             lanes;
	} ssdpc_wr_s;

endpackage : ssdpc_pkg
